//--- verilog/dual_dac_pkg.sv
// package: register map, field layout and encodings for the dual converter control block
`default_nettype none
package dual_dac_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 12;
    localparam logic [7:0] ADDR_DATA_LOW = 8'hd2;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hd3;
    localparam logic [7:0] ADDR_CONTROL = 8'hd4;
    localparam logic [7:0] PAGE_CH0 = 8'h00;
    localparam logic [7:0] PAGE_CH1 = 8'h01;
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_MODE_HI = 4;
    localparam int CTL_MODE_LO = 3;
    localparam int CTL_FMT_HI = 2;
    localparam int CTL_FMT_LO = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h9f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
    localparam int NUM_CH = 2;

    typedef enum logic [1:0] {
        MODE_ON_DEMAND = 2'b00,
        MODE_TIMER3 = 2'b01,
        MODE_TIMER4 = 2'b10,
        MODE_TIMER2 = 2'b11
    } update_mode_t;
endpackage : dual_dac_pkg
`default_nettype wire

//--- verilog/dac_justify.sv
// leaf: assembles the 12-bit converter word from the two data bytes per format
`default_nettype none
module dac_justify (
    input wire logic [dual_dac_pkg::DATA_W-1:0] data_high,
    input wire logic [dual_dac_pkg::DATA_W-1:0] data_low,
    input wire logic [2:0] justify_format,
    output logic [dual_dac_pkg::WORD_W-1:0] word
);
    import dual_dac_pkg::*;

    always_comb begin
        word = WORD_RESET;
        if (justify_format[2]) begin
            word = {data_high[7:0], data_low[7:4]};
        end else begin
            case (justify_format[1:0])
                2'b00: word = {data_high[3:0], data_low[7:0]};
                2'b01: word = {data_high[4:0], data_low[7:1]};
                2'b10: word = {data_high[5:0], data_low[7:2]};
                2'b11: word = {data_high[6:0], data_low[7:3]};
                default: word = WORD_RESET;
            endcase
        end
    end
endmodule // dac_justify
`default_nettype wire

//--- verilog/dual_dac_update_justify.sv
// top: register file, update scheduling and input latches for two converter channels
// Summary of operation
// - enable bit seven activates output, else shutdown
// - control bits six, five read zero
// - mode 00 updates on high-byte write
// - modes 01/10/11 update on timer 3/4/2
// - format 000: high[3:0] with low[7:0]
// - format 001: high[4:0] with low[7:1]
// - format 010: high[5:0] with low[7:2]
// - format 011: high[6:0] with low[7:3]
// - format 1xx: high[7:0] with low[7:4]
// - same offsets, page selects channel
// - all registers reset to zero
// - low-byte write held until high write
// - timer modes hold both bytes until overflow
// - latch word is twelve bits wide
`default_nettype none
module dual_dac_update_justify (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic timer4_overflow,
    output logic [dual_dac_pkg::WORD_W-1:0] ch0_latch_word,
    output logic [dual_dac_pkg::WORD_W-1:0] ch1_latch_word,
    output logic ch0_output_enable,
    output logic ch1_output_enable,
    output logic ch0_shutdown,
    output logic ch1_shutdown
);
    import dual_dac_pkg::*;

    // ****************************************
    // register file and latches
    // ****************************************
    logic [7:0] data_low [NUM_CH];
    logic [7:0] data_high [NUM_CH];
    logic [7:0] control [NUM_CH];
    logic [WORD_W-1:0] latch_word [NUM_CH];
    logic [7:0] next_data_low [NUM_CH];
    logic [7:0] next_data_high [NUM_CH];
    logic [7:0] next_control [NUM_CH];
    logic [WORD_W-1:0] next_latch_word [NUM_CH];
    logic [WORD_W-1:0] assembled [NUM_CH];
    logic [WORD_W-1:0] assembled_next [NUM_CH];
    logic [NUM_CH-1:0] sel;
    logic [NUM_CH-1:0] update_now;
    logic [NUM_CH-1:0] high_write;
    logic [7:0] next_rdata;
    logic next_hit;

    assign sel[0] = (sfr_page == PAGE_CH0);
    assign sel[1] = (sfr_page == PAGE_CH1);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // the word is assembled from the values being written this cycle so that a
            // high write and its update agree without an extra cycle of latency
            dac_justify u_just (
                .data_high(next_data_high[g]),
                .data_low(next_data_low[g]),
                .justify_format(next_control[g][CTL_FMT_HI:CTL_FMT_LO]),
                .word(assembled_next[g])
            );
            dac_justify u_just_cur (
                .data_high(data_high[g]),
                .data_low(data_low[g]),
                .justify_format(control[g][CTL_FMT_HI:CTL_FMT_LO]),
                .word(assembled[g])
            );

            always_comb begin
                next_data_low[g] = data_low[g];
                next_data_high[g] = data_high[g];
                next_control[g] = control[g];
                high_write[g] = 1'b0;
                if (sfr_wr && sel[g]) begin
                    if (sfr_addr == ADDR_DATA_LOW) begin
                        next_data_low[g] = sfr_wdata;
                    end
                    if (sfr_addr == ADDR_DATA_HIGH) begin
                        next_data_high[g] = sfr_wdata;
                        high_write[g] = 1'b1;
                    end
                    if (sfr_addr == ADDR_CONTROL) begin
                        next_control[g] = sfr_wdata & CTL_WRITE_MASK;
                    end
                end
            end

            always_comb begin
                update_now[g] = 1'b0;
                case (update_mode_t'(control[g][CTL_MODE_HI:CTL_MODE_LO]))
                    MODE_ON_DEMAND: update_now[g] = high_write[g];
                    MODE_TIMER3: update_now[g] = timer3_overflow;
                    MODE_TIMER4: update_now[g] = timer4_overflow;
                    MODE_TIMER2: update_now[g] = timer2_overflow;
                    default: update_now[g] = 1'b0;
                endcase
                next_latch_word[g] = update_now[g] ? assembled_next[g] : latch_word[g];
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    data_low[g] <= REG_RESET;
                    data_high[g] <= REG_RESET;
                    control[g] <= REG_RESET;
                    latch_word[g] <= WORD_RESET;
                end else begin
                    data_low[g] <= next_data_low[g];
                    data_high[g] <= next_data_high[g];
                    control[g] <= next_control[g];
                    latch_word[g] <= next_latch_word[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        next_rdata = sfr_rdata;
        next_hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (sfr_rd && sel[i]) begin
                if (sfr_addr == ADDR_DATA_LOW) begin
                    next_rdata = data_low[i];
                    next_hit = 1'b1;
                end
                if (sfr_addr == ADDR_DATA_HIGH) begin
                    next_rdata = data_high[i];
                    next_hit = 1'b1;
                end
                if (sfr_addr == ADDR_CONTROL) begin
                    next_rdata = control[i] & CTL_WRITE_MASK;
                    next_hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= REG_RESET;
            sfr_hit <= 1'b0;
        end else begin
            sfr_rdata <= next_rdata;
            sfr_hit <= next_hit;
        end
    end

    assign ch0_latch_word = latch_word[0];
    assign ch1_latch_word = latch_word[1];
    assign ch0_output_enable = control[0][CTL_EN_BIT];
    assign ch1_output_enable = control[1][CTL_EN_BIT];
    assign ch0_shutdown = ~control[0][CTL_EN_BIT];
    assign ch1_shutdown = ~control[1][CTL_EN_BIT];

    // ****************************************
    // checks
    // ****************************************
    property p_ondemand_update;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[0][4:3] == 2'b00 && sfr_wr && sel[0] && sfr_addr == ADDR_DATA_HIGH)
            |=> (ch0_latch_word == assembled[0]);
    endproperty
    a_ondemand_update: assert property (p_ondemand_update) else $error("on-demand update missed");

    property p_low_held;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[0][4:3] == 2'b00 && sfr_wr && sel[0] && sfr_addr == ADDR_DATA_LOW)
            |=> $stable(ch0_latch_word);
    endproperty
    a_low_held: assert property (p_low_held) else $error("low write changed output");

    property p_timer3;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[1][4:3] == 2'b01 && timer3_overflow) |=> (ch1_latch_word == assembled[1]);
    endproperty
    a_timer3: assert property (p_timer3) else $error("timer 3 update missed");

    property p_timer_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[0][4:3] != 2'b00 && !timer2_overflow && !timer3_overflow && !timer4_overflow)
            |=> $stable(ch0_latch_word);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer mode output moved");

    property p_timer2;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[0][4:3] == 2'b11 && timer2_overflow) |=> (ch0_latch_word == assembled[0]);
    endproperty
    a_timer2: assert property (p_timer2) else $error("timer 2 update missed");

    property p_unused_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        (sfr_rd && sfr_addr == ADDR_CONTROL && (sel[0] || sel[1])) |=> (sfr_rdata[6:5] == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

    property p_enable;
        @(posedge clk_sys) disable iff (!rst_b)
        (sfr_wr && sel[1] && sfr_addr == ADDR_CONTROL) |=> (ch1_output_enable == $past(sfr_wdata[7]));
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not follow write");

    property p_fmt9;
        @(posedge clk_sys) disable iff (!rst_b)
        control[0][2] |-> (assembled[0] == {data_high[0], data_low[0][7:4]});
    endproperty
    a_fmt9: assert property (p_fmt9) else $error("format 1xx wrong");

    property p_fmt5;
        @(posedge clk_sys) disable iff (!rst_b)
        (control[1][2:0] == 3'b000) |-> (assembled[1] == {data_high[1][3:0], data_low[1]});
    endproperty
    a_fmt5: assert property (p_fmt5) else $error("format 000 wrong");

    c_ondemand: cover property (@(posedge clk_sys) disable iff (!rst_b) update_now[0] && high_write[0]);
    c_timer4: cover property (@(posedge clk_sys) disable iff (!rst_b) control[1][4:3] == 2'b10 && timer4_overflow);
    c_both: cover property (@(posedge clk_sys) disable iff (!rst_b) update_now[0] && update_now[1]);
endmodule // dual_dac_update_justify
`default_nettype wire

//--- bench/dual_dac_update_justify_tb_top.sv
// testbench: register access, justification formats and timer-scheduled latch updates
`default_nettype none
module dual_dac_update_justify_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dual_dac_pkg::*;
    logic clk_sys, rst_b, sfr_wr, sfr_rd, sfr_hit, timer2_overflow, timer3_overflow, timer4_overflow;
    logic ch0_output_enable, ch1_output_enable, ch0_shutdown, ch1_shutdown;
    logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata;
    logic [WORD_W-1:0] ch0_latch_word, ch1_latch_word;
    logic [WORD_W-1:0] exp_w [2];
    int n_errors = 0;
    int n_tests = 0;
    dual_dac_update_justify dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer2_overflow(timer2_overflow),
        .timer3_overflow(timer3_overflow), .timer4_overflow(timer4_overflow),
        .ch0_latch_word(ch0_latch_word), .ch1_latch_word(ch1_latch_word),
        .ch0_output_enable(ch0_output_enable), .ch1_output_enable(ch1_output_enable),
        .ch0_shutdown(ch0_shutdown), .ch1_shutdown(ch1_shutdown));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_page = pg;
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] e, input logic h);
        @(negedge clk_sys);
        sfr_page = pg;
        sfr_addr = ad;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk("sfr_hit", {11'h000, h}, {11'h000, sfr_hit});
        if (h) chk("sfr_rdata", {4'h0, e}, {4'h0, sfr_rdata});
    endtask
    // one-cycle overflow pulses, bits ordered timer4, timer3, timer2
    task automatic pulse(input logic [2:0] t);
        @(negedge clk_sys);
        {timer4_overflow, timer3_overflow, timer2_overflow} = t;
        @(negedge clk_sys);
        {timer4_overflow, timer3_overflow, timer2_overflow} = 3'b000;
    endtask
    function automatic logic [11:0] just(input logic [7:0] h, input logic [7:0] l, input logic [2:0] f);
        case (f)
            3'b000: just = {h[3:0], l};
            3'b001: just = {h[4:0], l[7:1]};
            3'b010: just = {h[5:0], l[7:2]};
            3'b011: just = {h[6:0], l[7:3]};
            default: just = {h, l[7:4]};
        endcase
    endfunction
    task automatic chk_words;
        chk("ch0_latch_word", exp_w[0], ch0_latch_word);
        chk("ch1_latch_word", exp_w[1], ch1_latch_word);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk_words();
        chk("shutdown", 12'h003, {10'h000, ch1_shutdown, ch0_shutdown});
        chk("output_enable", 12'h000, {10'h000, ch1_output_enable, ch0_output_enable});
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 3; a++) rd(p[7:0], ADDR_DATA_LOW + a[7:0], 8'h00, 1'b1);
        end
    endtask
    task automatic t_control;
        for (int p = 0; p < 2; p++) begin
            wr(p[7:0], ADDR_CONTROL, 8'hff);
            rd(p[7:0], ADDR_CONTROL, 8'h9f, 1'b1);
            chk("enable", {11'h000, 1'b1}, {11'h000, p ? ch1_output_enable : ch0_output_enable});
            chk("shutdown", 12'h000, {11'h000, p ? ch1_shutdown : ch0_shutdown});
            wr(p[7:0], ADDR_CONTROL, 8'h00);
            chk("shutdown", 12'h001, {11'h000, p ? ch1_shutdown : ch0_shutdown});
        end
    endtask
    // every format on both pages; the low byte alone must not move the latch
    task automatic t_format;
        logic [7:0] h;
        logic [7:0] l;
        for (int p = 0; p < 2; p++) begin
            for (int f = 0; f < 8; f++) begin
                l = 8'h5a ^ f[7:0];
                h = 8'hb6 + f[7:0];
                wr(p[7:0], ADDR_CONTROL, {5'b10000, f[2:0]});
                wr(p[7:0], ADDR_DATA_LOW, l);
                chk_words();
                wr(p[7:0], ADDR_DATA_HIGH, h);
                exp_w[p] = just(h, l, f[2:0]);
                chk_words();
                rd(p[7:0], ADDR_DATA_LOW, l, 1'b1);
            end
        end
    endtask
    task automatic t_timer;
        logic [2:0] sel;
        logic [7:0] h;
        logic [7:0] l;
        for (int m = 1; m < 4; m++) begin
            sel = (m == 1) ? 3'b010 : (m == 2) ? 3'b100 : 3'b001;
            l = {m[3:0], 4'h9};
            h = {4'ha, m[3:0]};
            wr(PAGE_CH0, ADDR_CONTROL, {3'b000, m[1:0], 3'b100});
            wr(PAGE_CH1, ADDR_CONTROL, {3'b000, m[1:0], 3'b000});
            for (int p = 0; p < 2; p++) begin
                wr(p[7:0], ADDR_DATA_LOW, l);
                wr(p[7:0], ADDR_DATA_HIGH, h);
            end
            chk_words();
            pulse(~sel);
            chk_words();
            pulse(sel);
            exp_w[0] = just(h, l, 3'b100);
            exp_w[1] = just(h, l, 3'b000);
            chk_words();
        end
    endtask
    task automatic t_unmapped;
        wr(8'h02, ADDR_DATA_HIGH, 8'h77);
        rd(8'h02, ADDR_DATA_HIGH, 8'h00, 1'b0);
        rd(PAGE_CH0, 8'hd5, 8'h00, 1'b0);
        rd(PAGE_CH0, ADDR_DATA_HIGH, {4'ha, 4'h3}, 1'b1);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        {sfr_wr, sfr_rd, timer2_overflow, timer3_overflow, timer4_overflow} = 5'b00000;
        {sfr_page, sfr_addr, sfr_wdata} = 24'h00_0000;
        exp_w[0] = WORD_RESET;
        exp_w[1] = WORD_RESET;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset();
        t_control();
        t_format();
        t_timer();
        t_unmapped();
        summarize();
    end
endmodule // dual_dac_update_justify_tb_top
`default_nettype wire
